//--- design/port_pin_function_mux.sv
// Purpose: pin function multiplexer and port logic for ports 0, 1, 2 and 5
// Assumes: pins synchronous to ref_clk; AHB-Lite slave, word accesses only
// Notes: direction register bit 1 = input; all pin controls registered
//
// Notes on behaviour
// - Port 0 has four pins, each with its own direction bit and pull-up bit.
// - Port 1 has four pins, each with its own direction bit and pull-up bit.
// - Port 5 pins each choose input or output and have software pull-ups.
// - Each pin of ports 0 and 1 except port 1 pin 6 can be switched alone between port and alternate use; pin 6 stays a port pin.
// - External interrupt inputs detect rising, falling or both edges as programmed.
// - The output-stop input on port 0 pin 0 forces the six inverter outputs inactive.
// - Port 0 pin 3 can act as the converter start trigger input.
// - Port 1 pin 3 in alternate mode feeds the serial receiver.
// - Port 1 pin 4 in alternate mode drives the serial transmit data out.
// - Port 1 pin 7 in alternate mode is the flash mode select input.
// - The wide timer first input is its count clock and trigger of both captures.
// - The wide timer second input only triggers the first capture register.
// - The narrow timer clock pin feeds an external count clock to the narrow timer.
// - The six inverter outputs double as real-time port outputs and drive from reset.
// - Other port pins leave reset as inputs and are enabled by software.
// - Port 2 is input only, each pin a digital input or an analog input.
//
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module port_pin_function_mux (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // interrupt
  output logic irq,
  // port 0 pins
  input wire logic [3:0] p0_in,
  output logic [3:0] p0_out,
  output logic [3:0] p0_oe,
  output logic [3:0] p0_pullup,
  // port 1 pins (pins 3, 4, 6, 7)
  input wire logic [3:0] p1_in,
  output logic [3:0] p1_out,
  output logic [3:0] p1_oe,
  output logic [3:0] p1_pullup,
  // port 5 pins (pins 0, 3, 4)
  input wire logic [2:0] p5_in,
  output logic [2:0] p5_out,
  output logic [2:0] p5_oe,
  output logic [2:0] p5_pullup,
  // port 2 pins, input only
  input wire logic [3:0] p2_in,
  output logic [3:0] analog_in_sel,
  // inverter timer / real-time port pins
  output logic [5:0] inverter_timer_out,
  // peripheral side
  input wire logic [5:0] inverter_timer_value,
  output logic inverter_output_stop_in,
  output logic [4:0] ext_irq_event,
  output logic converter_trigger_in,
  output logic serial_rx_pin,
  input wire logic serial_tx_pin,
  output logic flash_mode_select_b,
  output logic wide_timer_clock_capture_in,
  output logic wide_timer_capture_in,
  output logic narrow_timer_clock_in,
  input wire logic wide_timer_out,
  input wire logic narrow_timer_out
);

  // --------------------------------------------------------------------
  // register state
  // --------------------------------------------------------------------
  logic [3:0] p0_data;
  logic [3:0] port0_direction_reg;
  logic [3:0] port0_pullup_reg;
  logic [3:0] p0_ctrl;
  logic [3:0] p1_data;
  logic [3:0] port1_direction_reg;
  logic [3:0] port1_pullup_reg;
  logic [3:0] p1_ctrl;
  logic [2:0] p5_data;
  logic [2:0] p5_dir;
  logic [2:0] p5_pu;
  logic [2:0] p5_ctrl;
  logic [2:0] p5_func;
  logic [3:0] p2_analog;
  logic [4:0] irq_rise;
  logic [4:0] irq_fall;
  logic [5:0] irq_status;
  logic [5:0] irq_mask;
  logic [6:0] inv_ctrl;

  // --------------------------------------------------------------------
  // ahb-lite slave
  // --------------------------------------------------------------------
  logic [7:0] dp_addr;
  logic dp_write;
  logic dp_read;
  logic [31:0] next_rdata;
  logic wr_en;
  logic [5:0] w1c;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dp_addr <= 8'h00;
      dp_write <= 1'b0;
      dp_read <= 1'b0;
    end else if (hready) begin
      dp_addr <= haddr[7:0];
      dp_write <= hsel & htrans[1] & hwrite;
      dp_read <= hsel & htrans[1] & ~hwrite;
    end else begin
      dp_read <= 1'b0;
    end
  end

  // reads take one wait state
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
    end else if (hready & hsel & htrans[1] & ~hwrite) begin
      hreadyout <= 1'b0;
    end else if (dp_read) begin
      hreadyout <= 1'b1;
      hrdata <= next_rdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    hresp <= 1'b0;
  end

  always_comb begin
    next_rdata = 32'h0;
    case (dp_addr)
      port_mux_pkg::OFS_P0_OUT: next_rdata = {28'h0, p0_data};
      port_mux_pkg::OFS_P0_DIR: next_rdata = {28'h0, port0_direction_reg};
      port_mux_pkg::OFS_P0_PU: next_rdata = {28'h0, port0_pullup_reg};
      port_mux_pkg::OFS_P0_CTRL: next_rdata = {28'h0, p0_ctrl};
      port_mux_pkg::OFS_P1_OUT: next_rdata = {28'h0, p1_data};
      port_mux_pkg::OFS_P1_DIR: next_rdata = {28'h0, port1_direction_reg};
      port_mux_pkg::OFS_P1_PU: next_rdata = {28'h0, port1_pullup_reg};
      port_mux_pkg::OFS_P1_CTRL: next_rdata = {28'h0, p1_ctrl};
      port_mux_pkg::OFS_P5_OUT: next_rdata = {29'h0, p5_data};
      port_mux_pkg::OFS_P5_DIR: next_rdata = {29'h0, p5_dir};
      port_mux_pkg::OFS_P5_PU: next_rdata = {29'h0, p5_pu};
      port_mux_pkg::OFS_P5_CTRL: next_rdata = {29'h0, p5_ctrl};
      port_mux_pkg::OFS_P5_FUNC: next_rdata = {29'h0, p5_func};
      port_mux_pkg::OFS_P2_ANALOG: next_rdata = {28'h0, p2_analog};
      // analog-selected port 2 pins read as zero
      port_mux_pkg::OFS_PIN_LEVEL: next_rdata = {17'h0, p5_in, p2_in & ~p2_analog,
                                                 p1_in, p0_in};
      port_mux_pkg::OFS_IRQ_RISE: next_rdata = {27'h0, irq_rise};
      port_mux_pkg::OFS_IRQ_FALL: next_rdata = {27'h0, irq_fall};
      port_mux_pkg::OFS_IRQ_STATUS: next_rdata = {26'h0, irq_status};
      port_mux_pkg::OFS_IRQ_MASK: next_rdata = {26'h0, irq_mask};
      port_mux_pkg::OFS_INV_CTRL: next_rdata = {25'h0, inv_ctrl};
      default: next_rdata = 32'h0;
    endcase
  end

  assign wr_en = dp_write;
  assign w1c = (wr_en && dp_addr == port_mux_pkg::OFS_IRQ_STATUS) ? hwdata[5:0] : 6'h00;

  // --------------------------------------------------------------------
  // register writes
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      p0_data <= port_mux_pkg::RST_ZERO4;
      port0_direction_reg <= port_mux_pkg::RST_DIR4;
      port0_pullup_reg <= port_mux_pkg::RST_ZERO4;
      p0_ctrl <= port_mux_pkg::RST_ZERO4;
    end else if (wr_en) begin
      case (dp_addr)
        port_mux_pkg::OFS_P0_OUT: p0_data <= hwdata[3:0];
        port_mux_pkg::OFS_P0_DIR: port0_direction_reg <= hwdata[3:0];
        port_mux_pkg::OFS_P0_PU: port0_pullup_reg <= hwdata[3:0];
        port_mux_pkg::OFS_P0_CTRL: p0_ctrl <= hwdata[3:0];
        default: p0_data <= p0_data;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      p1_data <= port_mux_pkg::RST_ZERO4;
      port1_direction_reg <= port_mux_pkg::RST_DIR4;
      port1_pullup_reg <= port_mux_pkg::RST_ZERO4;
      p1_ctrl <= port_mux_pkg::RST_ZERO4;
    end else if (wr_en) begin
      case (dp_addr)
        port_mux_pkg::OFS_P1_OUT: p1_data <= hwdata[3:0];
        port_mux_pkg::OFS_P1_DIR: port1_direction_reg <= hwdata[3:0];
        port_mux_pkg::OFS_P1_PU: port1_pullup_reg <= hwdata[3:0];
        port_mux_pkg::OFS_P1_CTRL: p1_ctrl <= hwdata[3:0];
        default: p1_data <= p1_data;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      p5_data <= port_mux_pkg::RST_ZERO3;
      p5_dir <= port_mux_pkg::RST_DIR3;
      p5_pu <= port_mux_pkg::RST_ZERO3;
      p5_ctrl <= port_mux_pkg::RST_ZERO3;
      p5_func <= port_mux_pkg::RST_ZERO3;
      p2_analog <= port_mux_pkg::RST_ZERO4;
    end else if (wr_en) begin
      case (dp_addr)
        port_mux_pkg::OFS_P5_OUT: p5_data <= hwdata[2:0];
        port_mux_pkg::OFS_P5_DIR: p5_dir <= hwdata[2:0];
        port_mux_pkg::OFS_P5_PU: p5_pu <= hwdata[2:0];
        port_mux_pkg::OFS_P5_CTRL: p5_ctrl <= hwdata[2:0];
        port_mux_pkg::OFS_P5_FUNC: p5_func <= hwdata[2:0];
        port_mux_pkg::OFS_P2_ANALOG: p2_analog <= hwdata[3:0];
        default: p5_data <= p5_data;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_rise <= 5'h00;
      irq_fall <= 5'h00;
      irq_mask <= port_mux_pkg::RST_ZERO6;
      inv_ctrl <= port_mux_pkg::RST_INV_CTRL;
    end else if (wr_en) begin
      case (dp_addr)
        port_mux_pkg::OFS_IRQ_RISE: irq_rise <= hwdata[4:0];
        port_mux_pkg::OFS_IRQ_FALL: irq_fall <= hwdata[4:0];
        port_mux_pkg::OFS_IRQ_MASK: irq_mask <= hwdata[5:0];
        port_mux_pkg::OFS_INV_CTRL: inv_ctrl <= hwdata[6:0];
        default: irq_rise <= irq_rise;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // external interrupt edge detection and sticky status
  // --------------------------------------------------------------------
  logic [4:0] irq_pin;
  logic [4:0] irq_prev;
  logic [4:0] irq_en;
  logic [5:0] event_now;
  logic stop_active;

  assign irq_pin = {p5_in[port_mux_pkg::P5_WIDE_A], p0_in};
  assign irq_en = {p5_ctrl[port_mux_pkg::P5_WIDE_A], p0_ctrl};
  assign stop_active = p0_ctrl[port_mux_pkg::P0_STOP] & p0_in[port_mux_pkg::P0_STOP];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_prev <= 5'h00;
    end else begin
      irq_prev <= irq_pin;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < port_mux_pkg::EXT_IRQS; gi++) begin : g_edge
      assign event_now[gi] = irq_en[gi] & ((irq_rise[gi] & irq_pin[gi] & ~irq_prev[gi]) |
                             (irq_fall[gi] & ~irq_pin[gi] & irq_prev[gi]));
    end
  endgenerate
  assign event_now[port_mux_pkg::EV_STOP] = stop_active;

  // a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_status <= port_mux_pkg::RST_ZERO6;
    end else begin
      irq_status <= (irq_status & ~w1c) | event_now;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq <= 1'b0;
      ext_irq_event <= 5'h00;
    end else begin
      irq <= |(((irq_status & ~w1c) | event_now) & irq_mask);
      ext_irq_event <= event_now[4:0];
    end
  end

  // --------------------------------------------------------------------
  // pin drive: port mode follows registers, control mode follows function
  // --------------------------------------------------------------------
  logic [3:0] next_p1_oe;
  logic [3:0] next_p1_out;
  logic [2:0] next_p5_oe;
  logic [2:0] next_p5_out;
  logic [2:0] p5_func_out;
  logic [2:0] p5_func_drv;

  // port 0 alternate functions are all inputs
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      p0_out <= 4'h0;
      p0_oe <= 4'h0;
      p0_pullup <= 4'h0;
    end else begin
      p0_out <= p0_data & ~p0_ctrl;
      p0_oe <= ~port0_direction_reg & ~p0_ctrl;
      p0_pullup <= port0_pullup_reg & port0_direction_reg;
    end
  end

  always_comb begin
    next_p1_oe = ~port1_direction_reg & ~p1_ctrl;
    next_p1_out = p1_data & ~p1_ctrl;
    if (p1_ctrl[port_mux_pkg::P1_TX]) begin
      next_p1_oe[port_mux_pkg::P1_TX] = 1'b1;
      next_p1_out[port_mux_pkg::P1_TX] = serial_tx_pin;
    end
    // pin 6 has no alternate function and stays a port pin
    if (p1_ctrl[2]) begin
      next_p1_oe[2] = ~port1_direction_reg[2];
      next_p1_out[2] = p1_data[2];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      p1_out <= 4'h0;
      p1_oe <= 4'h0;
      p1_pullup <= 4'h0;
    end else begin
      p1_out <= next_p1_out;
      p1_oe <= next_p1_oe;
      p1_pullup <= port1_pullup_reg & ~next_p1_oe;
    end
  end

  // port 5 function select on pins 0 and 4: 1 = timer output, 0 = timer input; pin 3 is always an input in control mode
  assign p5_func_out = {wide_timer_out, 1'b0, narrow_timer_out};
  assign p5_func_drv = {p5_func[2], 1'b0, p5_func[0]};

  always_comb begin
    next_p5_oe = ~p5_dir & ~p5_ctrl;
    next_p5_out = p5_data & ~p5_ctrl;
    next_p5_oe = next_p5_oe | (p5_ctrl & p5_func_drv);
    next_p5_out = next_p5_out | (p5_ctrl & p5_func_drv & p5_func_out);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      p5_out <= 3'h0;
      p5_oe <= 3'h0;
      p5_pullup <= 3'h0;
    end else begin
      p5_out <= next_p5_out;
      p5_oe <= next_p5_oe;
      p5_pullup <= p5_pu & ~next_p5_oe;
    end
  end

  // --------------------------------------------------------------------
  // inverter timer / real-time outputs, driven from reset
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      inverter_timer_out <= port_mux_pkg::INV_STOP_LEVEL;
    end else if (stop_active) begin
      inverter_timer_out <= port_mux_pkg::INV_STOP_LEVEL;
    end else if (inv_ctrl[port_mux_pkg::INV_SRC_BIT]) begin
      inverter_timer_out <= inv_ctrl[5:0];
    end else begin
      inverter_timer_out <= inverter_timer_value;
    end
  end

  // --------------------------------------------------------------------
  // inputs routed to peripherals (low when pin not in control mode, except serial_rx_pin which is then high)
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      inverter_output_stop_in <= 1'b0;
      converter_trigger_in <= 1'b0;
      serial_rx_pin <= 1'b1;
      flash_mode_select_b <= 1'b0;
      wide_timer_clock_capture_in <= 1'b0;
      wide_timer_capture_in <= 1'b0;
      narrow_timer_clock_in <= 1'b0;
      analog_in_sel <= 4'h0;
    end else begin
      inverter_output_stop_in <= stop_active;
      converter_trigger_in <= p0_ctrl[port_mux_pkg::P0_TRIG] &
                              p0_in[port_mux_pkg::P0_TRIG];
      // idle line is high when the receiver is not connected
      serial_rx_pin <= ~p1_ctrl[port_mux_pkg::P1_RX] | p1_in[port_mux_pkg::P1_RX];
      flash_mode_select_b <= p1_ctrl[port_mux_pkg::P1_FLASH] &
                             p1_in[port_mux_pkg::P1_FLASH];
      wide_timer_clock_capture_in <= p5_ctrl[port_mux_pkg::P5_WIDE_A] &
                                     p5_in[port_mux_pkg::P5_WIDE_A];
      wide_timer_capture_in <= p5_ctrl[port_mux_pkg::P5_WIDE_B] &
                               ~p5_func[port_mux_pkg::P5_WIDE_B] &
                               p5_in[port_mux_pkg::P5_WIDE_B];
      narrow_timer_clock_in <= p5_ctrl[port_mux_pkg::P5_NARROW] &
                               ~p5_func[port_mux_pkg::P5_NARROW] &
                               p5_in[port_mux_pkg::P5_NARROW];
      analog_in_sel <= p2_analog;
    end
  end

endmodule : port_pin_function_mux

//--- include/port_mux_pkg.sv
// Purpose: constants for the pin function multiplexer and port logic
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes: byte offsets, reset values and field positions live here
package port_mux_pkg;

  // --------------------------------------------------------------------
  // register byte offsets
  // --------------------------------------------------------------------
  localparam logic [7:0] OFS_P0_OUT = 8'h00;
  localparam logic [7:0] OFS_P0_DIR = 8'h04;
  localparam logic [7:0] OFS_P0_PU = 8'h08;
  localparam logic [7:0] OFS_P0_CTRL = 8'h0C;
  localparam logic [7:0] OFS_P1_OUT = 8'h10;
  localparam logic [7:0] OFS_P1_DIR = 8'h14;
  localparam logic [7:0] OFS_P1_PU = 8'h18;
  localparam logic [7:0] OFS_P1_CTRL = 8'h1C;
  localparam logic [7:0] OFS_P5_OUT = 8'h20;
  localparam logic [7:0] OFS_P5_DIR = 8'h24;
  localparam logic [7:0] OFS_P5_PU = 8'h28;
  localparam logic [7:0] OFS_P5_CTRL = 8'h2C;
  localparam logic [7:0] OFS_P5_FUNC = 8'h30;
  localparam logic [7:0] OFS_P2_ANALOG = 8'h34;
  localparam logic [7:0] OFS_PIN_LEVEL = 8'h38;
  localparam logic [7:0] OFS_IRQ_RISE = 8'h3C;
  localparam logic [7:0] OFS_IRQ_FALL = 8'h40;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h44;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h48;
  localparam logic [7:0] OFS_INV_CTRL = 8'h4C;

  // --------------------------------------------------------------------
  // reset values (direction: 1 = input)
  // --------------------------------------------------------------------
  localparam logic [3:0] RST_DIR4 = 4'hF;
  localparam logic [2:0] RST_DIR3 = 3'h7;
  localparam logic [3:0] RST_ZERO4 = 4'h0;
  localparam logic [2:0] RST_ZERO3 = 3'h0;
  localparam logic [5:0] RST_ZERO6 = 6'h00;
  localparam logic [6:0] RST_INV_CTRL = 7'h00;
  localparam logic [5:0] INV_STOP_LEVEL = 6'h00;

  // --------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------
  // interrupt events: 0..3 port 0 bits 0..3, 4 port 5 bit 1 (pin 3), 5 output stop
  localparam int IRQ_BITS = 6;
  localparam int EXT_IRQS = 5;
  localparam int EV_STOP = 5;
  // pin level word: port 0 [3:0], port 1 [7:4], port 2 [11:8], port 5 [14:12]
  localparam int LVL_P1 = 4;
  localparam int LVL_P2 = 8;
  localparam int LVL_P5 = 12;
  // inverter control: [5:0] real-time data, [6] 1 = real-time port drives
  localparam int INV_SRC_BIT = 6;
  // port 1 index of pins 3,4,6,7; port 5 index of pins 0,3,4
  localparam int P1_RX = 0;
  localparam int P1_TX = 1;
  localparam int P1_FLASH = 3;
  localparam int P5_NARROW = 0;
  localparam int P5_WIDE_A = 1;
  localparam int P5_WIDE_B = 2;
  localparam int P0_STOP = 0;
  localparam int P0_TRIG = 3;

endpackage : port_mux_pkg

//--- verification/pin_board_model.sv
// Purpose: board side of one port, resolving each pin from all drivers
// Assumes: port drive wins over board drive
// Notes: an undriven pin without pull-up shows the inverse of its last level
`timescale 1ns/1ps
module pin_board_model #(
  parameter int W = 4
) (
  // clock
  input wire logic ref_clk,
  // port side
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe,
  input wire logic [W-1:0] pin_pullup,
  // board side
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_en,
  output logic [W-1:0] pin_level
);
  logic [W-1:0] last;

  always_ff @(posedge ref_clk) begin
    last <= pin_level;
  end

  // a floating pin must not keep a stale value
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (pin_oe[i]) pin_level[i] = pin_out[i];
      else if (ext_en[i]) pin_level[i] = ext_val[i];
      else if (pin_pullup[i]) pin_level[i] = 1'b1;
      else pin_level[i] = ~last[i];
    end
  end
endmodule : pin_board_model

//--- verification/port_pin_function_mux_checker.sv
// Purpose: port-level assertions for the pin multiplexer
// Assumes: one clock, srst synchronous active high
// Notes: bound to the top module below
`timescale 1ns/1ps
module port_pin_function_mux_checker (
  // clock, reset and bus
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // pins
  input wire logic [3:0] p0_in,
  input wire logic [3:0] p1_in,
  input wire logic [2:0] p5_in,
  input wire logic [5:0] inverter_timer_out,
  // peripheral side
  input wire logic inverter_output_stop_in,
  input wire logic [4:0] ext_irq_event,
  input wire logic converter_trigger_in,
  input wire logic serial_rx_pin,
  input wire logic flash_mode_select_b,
  input wire logic wide_timer_clock_capture_in,
  input wire logic wide_timer_capture_in,
  input wire logic narrow_timer_clock_in
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  // --------------------------------------------------------------------
  // pin to peripheral paths
  // --------------------------------------------------------------------
  a_rx_from_pin: assert property (!serial_rx_pin |-> !$past(p1_in[0]))
    else $error("rx low with pin high");
  a_flash_from_pin: assert property (flash_mode_select_b |-> $past(p1_in[3]))
    else $error("flash select without pin");
  a_trig_from_pin: assert property (converter_trigger_in |-> $past(p0_in[3]))
    else $error("trigger without pin");
  a_wide_clk_pin: assert property (wide_timer_clock_capture_in |-> $past(p5_in[1]))
    else $error("wide clock without pin");
  a_wide_cap_pin: assert property (wide_timer_capture_in |-> $past(p5_in[2]))
    else $error("wide capture without pin");
  a_narrow_clk_pin: assert property (narrow_timer_clock_in |-> $past(p5_in[0]))
    else $error("narrow clock without pin");
  a_stop_forces_off: assert property (inverter_output_stop_in [*2] |->
    inverter_timer_out == port_mux_pkg::INV_STOP_LEVEL)
    else $error("outputs active in stop");
  a_event_needs_edge: assert property (ext_irq_event != 5'h00 |->
    (ext_irq_event & ~({$past(p5_in[1]), $past(p0_in)} ^
    {$past(p5_in[1], 2), $past(p0_in, 2)})) == 5'h00)
    else $error("event without edge");
  a_read_one_wait: assert property (hsel && hready && htrans[1] && !hwrite |=>
    !hreadyout ##1 hreadyout)
    else $error("read wait not one cycle");
  a_write_no_wait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response");

  c_event: cover property (ext_irq_event != 5'h00);
  c_stop: cover property (inverter_output_stop_in [*2]);
  c_rx_low: cover property (!serial_rx_pin);
endmodule : port_pin_function_mux_checker

bind port_pin_function_mux port_pin_function_mux_checker chk_i (.*);

//--- verification/port_pin_function_mux_tb.sv
// Purpose: self-checking bench for the pin multiplexer
// Assumes: 40 MHz ref_clk, AHB-Lite single word transfers, one slave
// Notes: board pins of ports 0, 1 and 5 come from pin_board_model instances; port 2 pins are held at 4'hF
`timescale 1ns/1ps
module port_pin_function_mux_tb;
  logic ref_clk = 1'b0, srst = 1'b1, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat;
  logic hreadyout, hresp, irq, inverter_output_stop_in, converter_trigger_in;
  logic serial_rx_pin, flash_mode_select_b, wide_timer_clock_capture_in;
  logic wide_timer_capture_in, narrow_timer_clock_in;
  logic serial_tx_pin = 1'b0, wide_timer_out = 1'b0, narrow_timer_out = 1'b0;
  logic [3:0] p0_in, p0_out, p0_oe, p0_pullup, p1_in, p1_out, p1_oe, p1_pullup;
  logic [3:0] p2_in = 4'hF, analog_in_sel, p0_ext = 4'h0, p1_ext = 4'h0, ext_en = 4'hF;
  logic [2:0] p5_in, p5_out, p5_oe, p5_pullup, p5_ext = 3'h0;
  logic [5:0] inverter_timer_out, inverter_timer_value = 6'h2A;
  logic [4:0] ext_irq_event;
  int bad_count = 0, check_count = 0;

  always #12.5 ref_clk = ~ref_clk;

  port_pin_function_mux dut (.ref_clk, .srst, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq,
    .p0_in, .p0_out, .p0_oe, .p0_pullup, .p1_in, .p1_out, .p1_oe, .p1_pullup,
    .p5_in, .p5_out, .p5_oe, .p5_pullup, .p2_in, .analog_in_sel, .inverter_timer_out,
    .inverter_timer_value, .inverter_output_stop_in, .ext_irq_event, .converter_trigger_in,
    .serial_rx_pin, .serial_tx_pin, .flash_mode_select_b, .wide_timer_clock_capture_in,
    .wide_timer_capture_in, .narrow_timer_clock_in, .wide_timer_out, .narrow_timer_out);
  pin_board_model #(.W(4)) board0 (.ref_clk, .pin_out(p0_out), .pin_oe(p0_oe),
    .pin_pullup(p0_pullup), .ext_val(p0_ext), .ext_en(ext_en), .pin_level(p0_in));
  pin_board_model #(.W(4)) board1 (.ref_clk, .pin_out(p1_out), .pin_oe(p1_oe),
    .pin_pullup(p1_pullup), .ext_val(p1_ext), .ext_en(ext_en), .pin_level(p1_in));
  pin_board_model #(.W(3)) board5 (.ref_clk, .pin_out(p5_out), .pin_oe(p5_oe),
    .pin_pullup(p5_pullup), .ext_val(p5_ext), .ext_en(ext_en[2:0]), .pin_level(p5_in));

  // --------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic wait_ready();
    int n = 0;
    do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 50);
    if (hreadyout !== 1'b1) chk(32'h0, 32'h1);
  endtask : wait_ready

  task automatic xfer(input logic [7:0] a, input logic wr_en, input logic [31:0] d);
    @(posedge ref_clk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr_en;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rdat = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(rdat, exp);
  endtask : rd

  task automatic tk();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : tk

  task automatic pins(input logic [3:0] a, input logic [3:0] b, input logic [2:0] c);
    @(posedge ref_clk);
    p0_ext <= a;
    p1_ext <= b;
    p5_ext <= c;
    tk();
  endtask : pins

  // --------------------------------------------------------------------
  // sequence
  // --------------------------------------------------------------------
  initial begin
    #50us;
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    tk();
    chk({p0_oe, p1_oe, p5_oe}, 11'h000);
    chk(inverter_timer_out, 6'h2A);
    rd(port_mux_pkg::OFS_P0_DIR, 32'hF);
    rd(port_mux_pkg::OFS_P1_DIR, 32'hF);
    rd(port_mux_pkg::OFS_P5_DIR, 32'h7);
    wr(port_mux_pkg::OFS_P0_OUT, 32'hA);
    wr(port_mux_pkg::OFS_P0_DIR, 32'hC);
    wr(port_mux_pkg::OFS_P0_PU, 32'hF);
    wr(port_mux_pkg::OFS_P1_OUT, 32'h5);
    wr(port_mux_pkg::OFS_P1_DIR, 32'h9);
    wr(port_mux_pkg::OFS_P1_PU, 32'hF);
    wr(port_mux_pkg::OFS_P5_OUT, 32'h5);
    wr(port_mux_pkg::OFS_P5_DIR, 32'h2);
    wr(port_mux_pkg::OFS_P5_PU, 32'h7);
    wr(port_mux_pkg::OFS_P2_ANALOG, 32'h3);
    tk();
    chk({p0_oe, p0_out & p0_oe, p0_pullup}, 12'h32C);
    chk({p1_oe, p1_out & p1_oe, p1_pullup}, 12'h649);
    chk({p5_oe, p5_out & p5_oe, p5_pullup}, 9'h16A);
    chk(analog_in_sel, 4'h3);
    rd(port_mux_pkg::OFS_PIN_LEVEL, 32'h5C42);
    wr(port_mux_pkg::OFS_P0_DIR, 32'hF);
    wr(port_mux_pkg::OFS_P1_DIR, 32'hF);
    wr(port_mux_pkg::OFS_P5_DIR, 32'h7);
    wr(port_mux_pkg::OFS_P1_CTRL, 32'hF);
    tk();
    chk({serial_rx_pin, flash_mode_select_b}, 2'h0);
    chk({p1_oe, p1_out & p1_oe}, 8'h20);
    @(posedge ref_clk);
    serial_tx_pin <= 1'b1;
    pins(4'h0, 4'h9, 3'h0);
    chk({serial_rx_pin, flash_mode_select_b}, 2'h3);
    chk({p1_oe, p1_out & p1_oe}, 8'h22);
    wr(port_mux_pkg::OFS_P5_CTRL, 32'h7);
    wr(port_mux_pkg::OFS_P5_FUNC, 32'h0);
    wr(port_mux_pkg::OFS_IRQ_RISE, 32'h13);
    wr(port_mux_pkg::OFS_IRQ_FALL, 32'h06);
    wr(port_mux_pkg::OFS_P0_CTRL, 32'hF);
    wr(port_mux_pkg::OFS_IRQ_STATUS, 32'h3F);
    pins(4'hF, 4'h9, 3'h7);
    chk({converter_trigger_in, inverter_output_stop_in}, 2'h3);
    chk(inverter_timer_out, 6'h00);
    chk({narrow_timer_clock_in, wide_timer_clock_capture_in, wide_timer_capture_in},
      3'h7);
    rd(port_mux_pkg::OFS_IRQ_STATUS, 32'h33);
    pins(4'h0, 4'h9, 3'h7);
    rd(port_mux_pkg::OFS_IRQ_STATUS, 32'h37);
    chk(inverter_timer_out, 6'h2A);
    wr(port_mux_pkg::OFS_IRQ_STATUS, 32'h37);
    rd(port_mux_pkg::OFS_IRQ_STATUS, 32'h00);
    pins(4'h2, 4'h9, 3'h7);
    chk(irq, 1'b0);
    wr(port_mux_pkg::OFS_IRQ_MASK, 32'h02);
    tk();
    chk(irq, 1'b1);
    wr(port_mux_pkg::OFS_IRQ_STATUS, 32'h02);
    tk();
    chk(irq, 1'b0);
    wr(port_mux_pkg::OFS_P5_FUNC, 32'h5);
    @(posedge ref_clk);
    narrow_timer_out <= 1'b1;
    tk();
    chk({p5_oe, p5_out & p5_oe}, 6'h29);
    wr(port_mux_pkg::OFS_INV_CTRL, 32'h55);
    tk();
    chk(inverter_timer_out, 6'h15);
    @(posedge ref_clk);
    ext_en <= 4'h0;
    tk();
    chk(p0_in, 4'hF);
    wr(8'h80, 32'hFFFF);
    rd(8'h80, 32'h0);
    report_and_stop();
  end
endmodule : port_pin_function_mux_tb
